// File: hw/ttsc_toggle_thermal_ctrl.sv
// toggle mode data selection and thermal shutdown control for 32 channels
`timescale 1ns/1ns
`default_nettype none
module ttsc_toggle_thermal_ctrl
  import ttsc_pkg::*;
#(
  parameter int CHANNELS = TTSC_CHANNELS,
  parameter int GROUP_SIZE = TTSC_GROUP_SIZE,
  parameter int DATA_W = TTSC_DATA_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic write_valid,
  input wire ttsc_write_t write_req,
  input wire logic load_output_strobe_n,
  input wire logic soft_power_up,
  input wire logic over_temp_raw,
  output ttsc_ctrl_t ctrl,
  output logic [CHANNELS-1:0][DATA_W-1:0] channel_code,
  output logic [CHANNELS-1:0] channel_from_b,
  output logic amp_enable,
  output logic thermal_shutdown,
  output logic over_temp
);

  localparam int GROUPS = CHANNELS / GROUP_SIZE;

  logic [DATA_W-1:0] data_a [CHANNELS];
  logic [DATA_W-1:0] data_b [CHANNELS];
  logic strobe_n_q;
  logic load_pulse;
  logic ctrl_write;
  logic data_write;
  logic shutdown;
  logic [GROUPS-1:0] load_from_b;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // group that a channel belongs to
  function automatic int group_of(input int ch);
    group_of = ch / GROUP_SIZE;
  endfunction

  // channel index of a write address
  function automatic int chan_of(input logic [4:0] addr);
    chan_of = int'(addr);
  endfunction

  // ----------------------------------------------------------------
  // write decoding
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_write = 1'b0;
    data_write = 1'b0;
    if (write_valid &&
        {write_req.register_select_hi, write_req.register_select_lo} == TTSC_SEL_SPECIAL &&
        write_req.channel_address_field == TTSC_CTRL_ADDR) begin
      ctrl_write = 1'b1;
    end else if (write_valid &&
        {write_req.register_select_hi, write_req.register_select_lo} == TTSC_SEL_DATA) begin
      data_write = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl.toggle_enable <= TTSC_CTRL_RESET[TTSC_TOGGLE_LSB +: 4];
      ctrl.thermal_protect_enable <= TTSC_CTRL_RESET[TTSC_THERMAL_POS];
    end else if (ctrl_write) begin
      ctrl.toggle_enable <= write_req.data[TTSC_TOGGLE_LSB +: 4];
      ctrl.thermal_protect_enable <= write_req.data[TTSC_THERMAL_POS];
    end
  end

  // ----------------------------------------------------------------
  // A and B holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        data_a[c] <= TTSC_DATA_RESET;
        data_b[c] <= TTSC_DATA_RESET;
      end
    end else if (data_write) begin
      if (write_req.ab_select == TTSC_AB_SEL_A) begin
        data_a[chan_of(write_req.channel_address_field)] <= write_req.data[DATA_W-1:0];
      end else if (ctrl.toggle_enable[group_of(chan_of(write_req.channel_address_field))]) begin
        data_b[chan_of(write_req.channel_address_field)] <= write_req.data[DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // load strobe: a falling edge is one active strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_n_q <= 1'b1;
    end else begin
      strobe_n_q <= load_output_strobe_n;
    end
  end

  always_comb begin
    load_pulse = strobe_n_q & ~load_output_strobe_n;
  end

  // per-group A/B phase tracking
  ttsc_toggle_phase #(
    .GROUPS(GROUPS)
  ) u_phase (
    .clk(clk),
    .srst(srst),
    .toggle_enable(ctrl.toggle_enable),
    .load_pulse(load_pulse),
    .load_from_b(load_from_b),
    .phase_b()
  );

  // ----------------------------------------------------------------
  // output codes: loaded from A or B on each strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        channel_code[c] <= TTSC_DATA_RESET;
        channel_from_b[c] <= 1'b0;
      end
    end else if (load_pulse) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (load_from_b[group_of(c)]) begin
          channel_code[c] <= data_b[c];
          channel_from_b[c] <= 1'b1;
        end else begin
          channel_code[c] <= data_a[c];
          channel_from_b[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // thermal protection
  // ----------------------------------------------------------------
  ttsc_thermal_guard u_thermal (
    .clk(clk),
    .srst(srst),
    .over_temp_raw(over_temp_raw),
    .thermal_protect_enable(ctrl.thermal_protect_enable),
    .soft_power_up(soft_power_up),
    .over_temp(over_temp),
    .shutdown(shutdown)
  );

  // amplifiers follow the latched shutdown state
  always_comb begin
    thermal_shutdown = shutdown;
    amp_enable = ~shutdown;
  end

endmodule // ttsc_toggle_thermal_ctrl
`default_nettype wire

// File: hw/ttsc_pkg.sv
// constants and carrier types for the toggle and thermal shutdown control block
// Functional notes
// - select 00 with address 01100 is control write
// - four control bits enable toggling per eight-channel group
// - every one of 32 channels holds A and B
// - B loads ignored unless group toggling enabled
// - first strobe after enabling selects A
// - each later strobe alternates between A and B
// - toggle rate follows strobe rate, no timer
// - after disabling, strobes load from A only
// - thermal shutdown works only while enable bit set
// - over-temperature with protection on powers amplifiers down
// - soft power-up when cool, or disable, re-enables amplifiers
package ttsc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int TTSC_CHANNELS = 32;
  localparam int TTSC_GROUP_SIZE = 8;
  localparam int TTSC_GROUPS = TTSC_CHANNELS / TTSC_GROUP_SIZE;
  localparam int TTSC_DATA_W = 14;
  localparam int TTSC_ADDR_W = 5;

  // ----------------------------------------------------------------
  // write decoding
  // ----------------------------------------------------------------
  localparam logic [1:0] TTSC_SEL_SPECIAL = 2'h0;    // special function space
  localparam logic [1:0] TTSC_SEL_DATA = 2'h3;       // channel data registers
  localparam logic [4:0] TTSC_CTRL_ADDR = 5'h0C;     // address 01100
  localparam logic TTSC_AB_SEL_A = 1'b0;             // write targets A register
  localparam logic TTSC_AB_SEL_B = 1'b1;             // write targets B register

  // ----------------------------------------------------------------
  // control register layout and reset value
  // ----------------------------------------------------------------
  localparam int TTSC_TOGGLE_LSB = 2;                // group 0 enable, groups follow upward
  localparam int TTSC_THERMAL_POS = 8;               // thermal protect enable
  localparam logic [13:0] TTSC_CTRL_RESET = 14'h0000;
  localparam logic [13:0] TTSC_DATA_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic register_select_hi;
    logic register_select_lo;
    logic [4:0] channel_address_field;
    logic ab_select;
    logic [13:0] data;
  } ttsc_write_t;

  typedef struct packed {
    logic [3:0] toggle_enable;
    logic thermal_protect_enable;
  } ttsc_ctrl_t;

endpackage

// File: hw/ttsc_thermal_guard.sv
// thermal shutdown latch with synchronised over-temperature input
`timescale 1ns/1ns
`default_nettype none
module ttsc_thermal_guard
  import ttsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic over_temp_raw,
  input wire logic thermal_protect_enable,
  input wire logic soft_power_up,
  output logic over_temp,
  output logic shutdown
);

  logic over_temp_meta;

  // ----------------------------------------------------------------
  // two-flop synchroniser for the analog comparator output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      over_temp_meta <= 1'b0;
      over_temp <= 1'b0;
    end else begin
      over_temp_meta <= over_temp_raw;
      over_temp <= over_temp_meta;
    end
  end

  // ----------------------------------------------------------------
  // shutdown latch: a hot die wins over a soft power-up release in the same cycle, clearing the enable wins over a hot die
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      shutdown <= 1'b0;
    end else if (!thermal_protect_enable) begin
      shutdown <= 1'b0;
    end else if (over_temp) begin
      shutdown <= 1'b1;
    end else if (soft_power_up) begin
      shutdown <= 1'b0;
    end
  end

endmodule // ttsc_thermal_guard
`default_nettype wire

// File: hw/ttsc_toggle_phase.sv
// per-group toggle phase: which of A or B the next strobe loads
`timescale 1ns/1ns
`default_nettype none
module ttsc_toggle_phase
  import ttsc_pkg::*;
#(
  parameter int GROUPS = TTSC_GROUPS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [GROUPS-1:0] toggle_enable,
  input wire logic load_pulse,
  output logic [GROUPS-1:0] load_from_b,
  output logic [GROUPS-1:0] phase_b
);

  // which register this strobe takes, per group
  always_comb begin
    load_from_b = phase_b & toggle_enable;
  end

  // ----------------------------------------------------------------
  // phase flips on each strobe and is held at A while a group is off,
  // so the first strobe after enabling loads A and every later one flips
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_b <= '0;
    end else begin
      for (int g = 0; g < GROUPS; g++) begin
        if (!toggle_enable[g]) begin
          phase_b[g] <= 1'b0;
        end else if (load_pulse) begin
          phase_b[g] <= ~phase_b[g];
        end
      end
    end
  end

endmodule // ttsc_toggle_phase
`default_nettype wire

// File: test/ttsc_ctrl_asserts.sv
// port assertions for the toggle and thermal shutdown control block
`timescale 1ns/1ns
`default_nettype none
module ttsc_ctrl_asserts
  import ttsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic write_valid,
  input wire ttsc_write_t write_req,
  input wire logic load_output_strobe_n,
  input wire logic soft_power_up,
  input wire logic over_temp_raw,
  input wire ttsc_ctrl_t ctrl,
  input wire logic [TTSC_CHANNELS-1:0][TTSC_DATA_W-1:0] channel_code,
  input wire logic [TTSC_CHANNELS-1:0] channel_from_b,
  input wire logic thermal_shutdown,
  input wire logic over_temp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // decoded control write, the value it carries, and protection left armed
  wire logic ctrl_wr = write_valid && write_req[21:20] == TTSC_SEL_SPECIAL &&
    write_req.channel_address_field == TTSC_CTRL_ADDR;
  wire logic [4:0] ctrl_val = {write_req.data[5:2], write_req.data[8]};
  wire logic keep = ctrl.thermal_protect_enable && !ctrl_wr;
  ctrl_load_a: assert property (ctrl_wr |=> ctrl == $past(ctrl_val))
    else $error("control write lost");
  temp_sync_a: assert property (over_temp == $past(over_temp_raw, 2))
    else $error("sync depth wrong");
  shut_set_a: assert property (over_temp && keep |=> thermal_shutdown)
    else $error("no shutdown when hot");
  shut_hold_a: assert property (thermal_shutdown && keep && !soft_power_up |=> thermal_shutdown)
    else $error("shutdown not latched");
  shut_free_a: assert property (
    thermal_shutdown && soft_power_up && !over_temp && !ctrl_wr |=> !thermal_shutdown)
    else $error("soft power-up ignored");
  protect_off_a: assert property (
    !ctrl.thermal_protect_enable && !ctrl_wr |=> !thermal_shutdown)
    else $error("shutdown while unprotected");
  strobe_only_a: assert property (
    !$fell(load_output_strobe_n) |=> $stable(channel_code) && $stable(channel_from_b))
    else $error("output moved without strobe");
  plain_load_a: assert property (
    $fell(load_output_strobe_n) && ctrl.toggle_enable == 4'h0 |=> channel_from_b == '0)
    else $error("B selected with toggle off");
endmodule // ttsc_ctrl_asserts
`default_nettype wire

// File: test/ttsc_host.sv
// host model: writes, load strobe and soft power-up
`timescale 1ns/1ns
`default_nettype none
module ttsc_host
  import ttsc_pkg::*;
(
  input wire logic clk,
  output var logic write_valid,
  output var ttsc_write_t write_req,
  output var logic load_output_strobe_n,
  output var logic soft_power_up
);
  // idle levels
  initial begin
    write_valid = 1'b0;
    write_req = '0;
    load_output_strobe_n = 1'b1;
    soft_power_up = 1'b0;
  end
  // one write; released request lines are scrambled, not held
  task automatic wr(input logic [1:0] sel, input logic [4:0] adr,
    input logic b, input logic [13:0] d);
    @(negedge clk);
    write_valid = 1'b1;
    write_req = {sel, adr, b, d};
    @(negedge clk);
    write_valid = 1'b0;
    write_req = ~write_req;
  endtask
  // strobe low for one cycle, high again on return
  task automatic strobe();
    @(negedge clk);
    load_output_strobe_n = 1'b0;
    @(negedge clk);
    load_output_strobe_n = 1'b1;
  endtask
  // one-cycle soft power-up pulse
  task automatic power_up();
    @(negedge clk);
    soft_power_up = 1'b1;
    @(negedge clk);
    soft_power_up = 1'b0;
  endtask
endmodule // ttsc_host
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the toggle and thermal shutdown control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ttsc_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, over_temp_raw = 1'b0;
  logic write_valid, load_output_strobe_n, soft_power_up, amp_enable, thermal_shutdown, over_temp;
  ttsc_write_t write_req;
  ttsc_ctrl_t ctrl;
  logic [TTSC_CHANNELS-1:0][TTSC_DATA_W-1:0] channel_code;
  logic [TTSC_CHANNELS-1:0] channel_from_b;
  int err_total = 0, checked = 0;
  // 20 MHz clock, design and host
  always #25 clk = ~clk;
  ttsc_toggle_thermal_ctrl ttsc_toggle_thermal_ctrl_inst (.clk(clk), .srst(srst),
    .write_valid(write_valid), .write_req(write_req), .load_output_strobe_n(load_output_strobe_n),
    .soft_power_up(soft_power_up), .over_temp_raw(over_temp_raw), .ctrl(ctrl),
    .channel_code(channel_code), .channel_from_b(channel_from_b), .amp_enable(amp_enable),
    .thermal_shutdown(thermal_shutdown), .over_temp(over_temp));
  ttsc_host ttsc_host_inst (.clk(clk), .write_valid(write_valid), .write_req(write_req),
    .load_output_strobe_n(load_output_strobe_n), .soft_power_up(soft_power_up));
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cw(input logic [13:0] d);
    ttsc_host_inst.wr(TTSC_SEL_SPECIAL, TTSC_CTRL_ADDR, 1'b0, d);
  endtask
  task automatic dw(input logic [4:0] a, input logic b, input logic [13:0] d);
    ttsc_host_inst.wr(TTSC_SEL_DATA, a, b, d);
  endtask
  task automatic results();
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // groups 0 and 2 toggle, group 1 refuses B, four strobes alternate
  task automatic t_toggle();
    cw(14'h0014);
    ttsc_host_inst.wr(2'h0, 5'h0d, 1'b0, 14'h0000);
    chk(ctrl, 5'h0a);
    dw(5'd0, 1'b0, 14'h1111);
    dw(5'd8, 1'b0, 14'h0444);
    dw(5'd31, 1'b0, 14'h3fff);
    dw(5'd0, 1'b1, 14'h2222);
    dw(5'd8, 1'b1, 14'h3333);
    for (int i = 0; i < 4; i++) begin
      ttsc_host_inst.strobe();
      chk(channel_code[0], i[0] ? 14'h2222 : 14'h1111);
      chk(channel_from_b[0], i[0]);
      chk(channel_code[8], 14'h0444);
      chk(channel_code[31], 14'h3fff);
    end
  endtask
  // toggle off after a B phase, stray writes, then on again
  task automatic t_disable();
    cw(14'h0000);
    ttsc_host_inst.wr(2'h1, 5'd0, 1'b0, 14'h0abc);
    ttsc_host_inst.strobe();
    chk(channel_code[0], 14'h1111);
    chk(channel_from_b[0], 1'b0);
    dw(5'd0, 1'b1, 14'h0abc);
    cw(14'h003c);
    for (int i = 0; i < 2; i++) begin
      ttsc_host_inst.strobe();
      chk(channel_code[0], i[0] ? 14'h2222 : 14'h1111);
      chk(channel_code[8], i[0] ? 14'h0000 : 14'h0444);
      chk(channel_code[31], i[0] ? 14'h0000 : 14'h3fff);
    end
  endtask
  // heat with protection off and on, power-up hot and cool, disable
  task automatic t_thermal();
    over_temp_raw = 1'b1;
    idle(5);
    chk(over_temp, 1'b1);
    chk(thermal_shutdown, 1'b0);
    cw(14'h0100);
    idle(2);
    chk(amp_enable, 1'b0);
    ttsc_host_inst.power_up();
    over_temp_raw = 1'b0;
    idle(4);
    chk(thermal_shutdown, 1'b1);
    ttsc_host_inst.power_up();
    chk(amp_enable, 1'b1);
    over_temp_raw = 1'b1;
    idle(4);
    chk(thermal_shutdown, 1'b1);
    cw(14'h0000);
    idle(1);
    chk(thermal_shutdown, 1'b0);
    over_temp_raw = 1'b0;
  endtask
  // reset, then the scenarios
  initial begin
    idle(16);
    srst = 1'b0;
    t_toggle();
    t_disable();
    t_thermal();
    results();
  end
  // watchdog at about twenty-five times the expected run
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule // tb_top
bind ttsc_toggle_thermal_ctrl ttsc_ctrl_asserts ttsc_ctrl_asserts_inst (.clk(clk), .srst(srst),
  .write_valid(write_valid), .write_req(write_req), .load_output_strobe_n(load_output_strobe_n),
  .soft_power_up(soft_power_up), .over_temp_raw(over_temp_raw), .ctrl(ctrl),
  .channel_code(channel_code), .channel_from_b(channel_from_b),
  .thermal_shutdown(thermal_shutdown), .over_temp(over_temp));
`default_nettype wire
